// ### core/srs_pkg.sv
// Purpose: constants shared by the switch reset sequencer
// Assumes: 200 MHz system clock, AHB-Lite register access
// Notes:   times are kept in ns and turned into cycle counts in the module
`default_nettype none
package srs_pkg;
  // clock period and documented reset durations in ns
  localparam int CLK_NS     = 5;
  localparam int POR_NS     = 23_000_000;
  localparam int PIN_NS     = 760_000;
  localparam int SOFT_NS    = 760_000;
  localparam int PHY_NS     = 110_000;
  localparam int VPHY_NS    = 1_000;
  localparam int EE_BYTE_NS = 91_000;
  // register byte offsets
  localparam logic [7:0] OFF_BYTE_TEST = 8'h00;
  localparam logic [7:0] OFF_HARDWARE_CONFIG_REG    = 8'h04;
  localparam logic [7:0] OFF_RESET_CONTROL_REG = 8'h08;
  localparam logic [7:0] OFF_IRQ_STS   = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h10;
  localparam logic [7:0] OFF_STRAP     = 8'h14;
  localparam logic [7:0] OFF_SCRATCH   = 8'h18;
  // field positions
  localparam int HW_READY_BIT = 0;
  localparam int CTL_DIG_BIT  = 0;
  localparam int CTL_PHY_LSB  = 1;
  localparam int IRQ_RDY_BIT  = 0;
  localparam int IRQ_PHY_LSB  = 1;
  localparam int NUM_PHY      = 3;
  localparam int IRQ_W        = 4;
  // sub-module reset output indices
  localparam int RST_SYS    = 0;
  localparam int RST_IRQ    = 1;
  localparam int RST_FABRIC = 2;
  localparam int RST_PMI    = 3;
  localparam int RST_I2C    = 4;
  localparam int RST_SMI    = 5;
  localparam int RST_EE     = 6;
  localparam int RST_GPIO   = 7;
  localparam int NUM_RST    = 8;
  // sequencer states
  typedef enum logic [1:0] {ST_CHIP_HOLD, ST_SOFT_HOLD, ST_LOAD, ST_READY} srs_state_e;
endpackage
`default_nettype wire

// ### core/srs_sequencer.sv
// Purpose: reset sequencing for a three-port managed switch with AHB-Lite registers
// Assumes: hresetn is the power-on reset; pin and straps synchronous to hclk
// Notes:   EEPROM loader is outside; it gets a start pulse and answers with done
// How it works
// - chip reset asserts every internal reset
// - straps captured only after chip resets release
// - loader starts after every non-PHY reset
// - power-up always produces power-on reset
// - low reset pin starts chip reset
// - digital reset bit resets all but PHYs
// - digital reset keeps latched straps
// - soft-reset-surviving bits unchanged by digital reset
// - byte test invalid until serial resets end
// - ready clear during resets, set after load
// - power-on hold about 23 ms
// - pin reset hold about 760 us
// - digital reset hold about 760 us
// - single PHY reset touches only that PHY
// - PHY reset bits self-clear after 110 us; the last PHY's bit clears after 1 us
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
`default_nettype none
module srs_sequencer
  import srs_pkg::*;
#(
  parameter int          POR_CYC      = POR_NS / CLK_NS,
  parameter int          PIN_CYC      = PIN_NS / CLK_NS,
  parameter int          SOFT_CYC     = SOFT_NS / CLK_NS,
  parameter int          PHY_CYC      = PHY_NS / CLK_NS,
  parameter int          VPHY_CYC     = VPHY_NS / CLK_NS,
  parameter int          SER_CYC      = 16,
  parameter int          STRAP_W      = 8,
  parameter logic [31:0] BYTE_PATTERN = 32'h0123_4567, // arbitrary value
  parameter int          CW           = 23
)(
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic [31:0]              hrdata,
  output logic                     hresp,
  input  wire logic                ext_reset_pin_low,
  input  wire logic [STRAP_W-1:0]  strap_pins,
  input  wire logic                ee_load_done,
  output logic                     ee_load_start,
  output logic [NUM_RST-1:0]       mod_rst,
  output logic [NUM_PHY-1:0]       phy_rst,
  output logic [STRAP_W-1:0]       strap_val,
  output logic                     dev_ready,
  output logic                     irq
);
  localparam logic [CW-1:0] POR_LIM  = CW'(POR_CYC - 1);
  localparam logic [CW-1:0] PIN_LIM  = CW'(PIN_CYC - 1);
  localparam logic [CW-1:0] SOFT_LIM = CW'(SOFT_CYC - 1);
  localparam logic [CW-1:0] SER_LIM  = CW'(SER_CYC);

  // register hit for a byte offset inside the first 256 bytes
  function automatic logic reg_hit(input logic [31:0] a, input logic [7:0] off);
    reg_hit = (a[31:8] == 24'h00_0000) && (a[7:0] == off);
  endfunction

  srs_state_e           st_q, st_d;
  logic [CW-1:0]        cnt_q, cnt_d;
  logic                 por_q, por_d;
  logic [STRAP_W-1:0]   strap_q, strap_d;
  logic                 ee_start_q, ee_start_d;
  logic [NUM_RST-1:0]   mrst_q, mrst_d;
  logic                 rdy_q, rdy_d;
  logic                 dig_wr;
  logic [NUM_PHY-1:0]   phy_set;
  logic [NUM_PHY-1:0]   phy_bit_q, phy_bit_d;
  logic [NUM_PHY-1:0]   phy_done;
  logic [NUM_PHY-1:0]   prst_q, prst_d;
  logic [CW-1:0]        pcnt_q [NUM_PHY];
  logic [CW-1:0]        pcnt_d [NUM_PHY];
  logic                 chip_d;

  // sequencer next state: chip hold, soft hold, loader run, ready
  always_comb
  begin
    st_d       = st_q;
    cnt_d      = cnt_q;
    por_d      = por_q;
    strap_d    = strap_q;
    ee_start_d = 1'b0;
    case (st_q)
      ST_CHIP_HOLD:
      begin
        if (cnt_q >= (por_q ? POR_LIM : PIN_LIM))
        begin
          strap_d    = strap_pins;
          st_d       = ST_LOAD;
          ee_start_d = 1'b1;
          cnt_d      = '0;
          por_d      = 1'b0;
        end
        else
          cnt_d = cnt_q + CW'(1);
      end
      ST_SOFT_HOLD:
      begin
        if (cnt_q >= SOFT_LIM)
        begin
          st_d       = ST_LOAD;
          ee_start_d = 1'b1;
          cnt_d      = '0;
        end
        else
          cnt_d = cnt_q + CW'(1);
      end
      ST_LOAD:
        if (ee_load_done)
          st_d = ST_READY;
      ST_READY:
        if (dig_wr)
        begin
          st_d  = ST_SOFT_HOLD;
          cnt_d = '0;
        end
      default:
        st_d = ST_CHIP_HOLD;
    endcase
    // pin low restarts the chip hold from any state
    if (ext_reset_pin_low)
    begin
      st_d       = ST_CHIP_HOLD;
      cnt_d      = '0;
      ee_start_d = 1'b0;
    end
    chip_d = (st_d == ST_CHIP_HOLD);
    // every sub-module held in both holds; serial slaves freed early
    for (int k = 0; k < NUM_RST; k++)
      mrst_d[k] = chip_d || (st_d == ST_SOFT_HOLD);
    mrst_d[RST_I2C] = mrst_d[RST_I2C] && (cnt_d < SER_LIM);
    mrst_d[RST_SMI] = mrst_d[RST_SMI] && (cnt_d < SER_LIM);
    rdy_d = (st_d == ST_READY);
  end

  // sequencer registers; power-on reset enters the long hold
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q       <= ST_CHIP_HOLD;
      cnt_q      <= '0;
      por_q      <= 1'b1;
      strap_q    <= '0;
      ee_start_q <= 1'b0;
      mrst_q     <= '1;
      rdy_q      <= 1'b0;
    end
    else
    begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      por_q      <= por_d;
      strap_q    <= strap_d;
      ee_start_q <= ee_start_d;
      mrst_q     <= mrst_d;
      rdy_q      <= rdy_d;
    end
  end

  // per-PHY single-module resets, self-clearing after their own time
  generate
    for (genvar i = 0; i < NUM_PHY; i++)
    begin : g_phy
      localparam logic [CW-1:0] LIM = CW'((i == NUM_PHY - 1 ? VPHY_CYC : PHY_CYC) - 1);
      always_comb
      begin
        phy_bit_d[i] = phy_bit_q[i];
        pcnt_d[i]    = pcnt_q[i];
        phy_done[i]  = 1'b0;
        if (phy_bit_q[i])
        begin
          if (pcnt_q[i] >= LIM)
          begin
            phy_bit_d[i] = 1'b0;
            phy_done[i]  = 1'b1;
            pcnt_d[i]    = '0;
          end
          else
            pcnt_d[i] = pcnt_q[i] + CW'(1);
        end
        else if (phy_set[i])
        begin
          phy_bit_d[i] = 1'b1;
          pcnt_d[i]    = '0;
        end
        if (chip_d)
        begin
          phy_bit_d[i] = 1'b0;
          pcnt_d[i]    = '0;
        end
        prst_d[i] = chip_d || phy_bit_d[i];
      end
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          phy_bit_q[i] <= 1'b0;
          pcnt_q[i]    <= '0;
          prst_q[i]    <= 1'b1;
        end
        else
        begin
          phy_bit_q[i] <= phy_bit_d[i];
          pcnt_q[i]    <= pcnt_d[i];
          prst_q[i]    <= prst_d[i];
        end
      end
    end
  endgenerate

  logic                 wr_q, wr_d;
  logic [31:0]          waddr_q, waddr_d;
  logic [31:0]          rdata_q, rdata_d;
  logic [IRQ_W-1:0]     sts_q, sts_d, mask_q, mask_d, evt;
  logic [31:0]          scratch_q, scratch_d;
  logic                 irq_q, irq_d;
  logic                 ahb_go;

  // bus slave: zero wait states, reads answered in the data phase
  always_comb
  begin
    ahb_go    = hsel && htrans[1] && hready;
    wr_d      = ahb_go && hwrite;
    waddr_d   = haddr;
    rdata_d   = '0;
    sts_d     = sts_q;
    mask_d    = mask_q;
    scratch_d = scratch_q;
    dig_wr    = 1'b0;
    phy_set   = '0;
    if (ahb_go && !hwrite)
    begin
      if (reg_hit(haddr, OFF_BYTE_TEST))
        rdata_d = mrst_q[RST_I2C] ? 32'h0000_0000 : BYTE_PATTERN;
      else if (reg_hit(haddr, OFF_HARDWARE_CONFIG_REG))
        rdata_d[HW_READY_BIT] = rdy_q;
      else if (reg_hit(haddr, OFF_RESET_CONTROL_REG))
      begin
        rdata_d[CTL_DIG_BIT] = (st_q == ST_SOFT_HOLD);
        rdata_d[CTL_PHY_LSB +: NUM_PHY] = phy_bit_q;
      end
      else if (rdy_q && reg_hit(haddr, OFF_IRQ_STS))
        rdata_d[IRQ_W-1:0] = sts_q;
      else if (rdy_q && reg_hit(haddr, OFF_IRQ_MASK))
        rdata_d[IRQ_W-1:0] = mask_q;
      else if (rdy_q && reg_hit(haddr, OFF_STRAP))
        rdata_d[STRAP_W-1:0] = strap_q;
      else if (rdy_q && reg_hit(haddr, OFF_SCRATCH))
        rdata_d = scratch_q;
    end
    // writes land only once the device is ready
    if (wr_q && rdy_q)
    begin
      if (reg_hit(waddr_q, OFF_RESET_CONTROL_REG))
      begin
        dig_wr  = hwdata[CTL_DIG_BIT];
        phy_set = hwdata[CTL_PHY_LSB +: NUM_PHY];
      end
      if (reg_hit(waddr_q, OFF_IRQ_MASK))
        mask_d = hwdata[IRQ_W-1:0];
      if (reg_hit(waddr_q, OFF_SCRATCH))
        scratch_d = hwdata;
      if (reg_hit(waddr_q, OFF_IRQ_STS))
        sts_d = sts_q & ~hwdata[IRQ_W-1:0];
    end
    // events win over a same-cycle clear
    evt = '0;
    evt[IRQ_RDY_BIT] = rdy_d && !rdy_q;
    evt[IRQ_PHY_LSB +: NUM_PHY] = phy_done;
    sts_d = sts_d | evt;
    // interrupt block is reset by every chip and digital reset
    if (mrst_d[RST_IRQ])
    begin
      sts_d  = '0;
      mask_d = '0;
    end
    if (chip_d)
      scratch_d = '0;
    irq_d = |(sts_d & mask_d);
  end

  // bus and register flops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q      <= 1'b0;
      waddr_q   <= '0;
      rdata_q   <= '0;
      sts_q     <= '0;
      mask_q    <= '0;
      scratch_q <= '0;
      irq_q     <= 1'b0;
    end
    else
    begin
      wr_q      <= wr_d;
      waddr_q   <= waddr_d;
      rdata_q   <= rdata_d;
      sts_q     <= sts_d;
      mask_q    <= mask_d;
      scratch_q <= scratch_d;
      irq_q     <= irq_d;
    end
  end

  // outputs straight from flops; response is always ready and OKAY
  assign hreadyout     = hresetn ? 1'b1 : 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = rdata_q;
  assign ee_load_start = ee_start_q;
  assign mod_rst       = mrst_q;
  assign phy_rst       = prst_q;
  assign strap_val     = strap_q;
  assign dev_ready     = rdy_q;
  assign irq           = irq_q;

  // checks on the sequencing
  AST_PIN_ALL: assert property (@(posedge hclk) disable iff (!hresetn)
    ext_reset_pin_low |=> (&mrst_q) && (&prst_q) && !rdy_q)
    else $error("pin reset did not assert every reset");
  AST_SOFT_NO_PHY: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == ST_SOFT_HOLD) |-> (prst_q == phy_bit_q) && mrst_q[RST_FABRIC])
    else $error("digital reset touched a PHY or missed the fabric");
  AST_STRAP_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    ($past(st_q) != ST_CHIP_HOLD) |-> $stable(strap_q))
    else $error("straps changed outside a chip reset");
  AST_STRAP_CAP: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == ST_CHIP_HOLD) ##1 (st_q == ST_LOAD) |-> strap_q == $past(strap_pins))
    else $error("straps not captured at chip reset release");
  AST_EE_START: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st_q == ST_LOAD) |-> ee_load_start)
    else $error("loader not started");
  AST_READY_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
    mrst_q[RST_SYS] |-> !dev_ready)
    else $error("ready set during reset");
  AST_BYTE_TEST: assert property (@(posedge hclk) disable iff (!hresetn)
    (hsel && htrans[1] && hready && !hwrite && reg_hit(haddr, OFF_BYTE_TEST))
    |=> (hrdata == (($past(mrst_q[RST_I2C])) ? 32'h0000_0000 : BYTE_PATTERN)))
    else $error("byte test value wrong");
  AST_PHY_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
    phy_bit_q[0] |-> pcnt_q[0] <= CW'(PHY_CYC - 1))
    else $error("PHY reset bit overstayed");
  AST_SOFT_LEN: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == ST_SOFT_HOLD) |-> cnt_q <= SOFT_LIM)
    else $error("digital reset overstayed");
  AST_SURVIVE: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == ST_SOFT_HOLD) && !ext_reset_pin_low |=> $stable(scratch_q))
    else $error("surviving register changed in digital reset");
  AST_PHY_ONLY: assert property (@(posedge hclk) disable iff (!hresetn)
    ($rose(phy_bit_q[0]) && !ext_reset_pin_low) |-> $stable(mrst_q) && $stable(st_q))
    else $error("single PHY reset spread");
  COV_POR_DONE: cover property (@(posedge hclk) disable iff (!hresetn) $rose(dev_ready));
  COV_SOFT: cover property (@(posedge hclk) disable iff (!hresetn) $rose(st_q == ST_SOFT_HOLD));
  COV_PHY: cover property (@(posedge hclk) disable iff (!hresetn) phy_done[0]);
  COV_IRQ: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
endmodule
`default_nettype wire

// ### test/srs_loader_model.sv
// Purpose: loader partner answering the sequencer start pulse with done
// Assumes: one done pulse per start, after a per-byte delay
// Notes:   the byte count comes from the bench, so loads are short or long
`default_nettype none
module srs_loader_model #(
  parameter int BYTE_CYC = 3
)(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [3:0] nbytes,
  output logic            done
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_q;
  // done comes only after a start and the per-byte load time
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 0;
      done  <= 1'b0;
    end
    else
    begin
      done <= (cnt_q == 1);
      if (start)
        cnt_q <= 2 + int'(nbytes) * BYTE_CYC;
      else if (cnt_q != 0)
        cnt_q <= cnt_q - 1;
    end
  end
endmodule
`default_nettype wire

// ### test/testbench.sv
// Purpose: self-checking bench for the switch reset sequencer
// Assumes: zero-wait AHB-Lite slave, shortened hold counts
// Notes:   expectations come from the bench's own record of straps and scratch
`default_nettype none
module testbench import srs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] PAT  = 32'h0123_4567;
  localparam int          PHYC = 10;
  localparam int          VPHYC = 4;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, pin = 0;
  logic        irq, dev_ready, ee_start, ee_done, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, d, scr;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [2:0]  phy_rst;
  logic [7:0]  straps = 0, strap_val, mod_rst, old;
  logic [3:0]  nbytes = 0;
  int          error_cnt = 0, checked = 0, n;

  // free-running system clock
  always #2.5 hclk = ~hclk;

  srs_sequencer #(.POR_CYC(40), .PIN_CYC(20), .SOFT_CYC(20), .PHY_CYC(PHYC),
    .VPHY_CYC(VPHYC), .SER_CYC(4), .BYTE_PATTERN(PAT)) dut_u (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
    .hrdata, .hresp, .ext_reset_pin_low(pin), .strap_pins(straps),
    .ee_load_done(ee_done), .ee_load_start(ee_start), .mod_rst, .phy_rst,
    .strap_val, .dev_ready, .irq);

  srs_loader_model ldr_u (.clk(hclk), .rst_n(hresetn),
    .start(ee_start), .nbytes(nbytes), .done(ee_done));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one single transfer; read data lands in d
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  // read until the masked field shows the wanted value
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    n = 0;
    do
    begin
      bus(1'b0, a, 0);
      n++;
    end
    while ((d & m) !== v && n < 300);
    chk("poll", v, d & m);
  endtask

  task automatic resets(input logic [31:0] m, input logic [31:0] p, input logic r);
    chk("mod_rst", m, 32'(mod_rst));
    chk("phy_rst", p, 32'(phy_rst));
    chk("ready", 32'(r), 32'(dev_ready));
  endtask

  task summarize;
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // watchdog against a hung handshake or poll
  initial
  begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    summarize();
  end

  initial
  begin
    n = $urandom(32'h500F101A);
    straps <= 8'($urandom);
    nbytes <= 4'($urandom);
    repeat (3) @(posedge hclk);
    resets(32'hFF, 32'h7, 1'b0);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, OFF_BYTE_TEST, 0);
    chk("byte_early", 0, d);
    poll(OFF_BYTE_TEST, 32'hFFFFFFFF, PAT);
    poll(OFF_HARDWARE_CONFIG_REG, 32'h1, 32'h1);
    bus(1'b0, OFF_STRAP, 0);
    chk("strap_reg", 32'(straps), d);
    chk("strap_val", 32'(straps), 32'(strap_val));
    $display("test power_on done");
    // each single-module reset, with its interrupt raised, masked, cleared
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, OFF_IRQ_STS, 32'hF);
      bus(1'b1, OFF_IRQ_MASK, 32'h2 << i);
      bus(1'b1, OFF_RESET_CONTROL_REG, 32'h2 << i);
      repeat (2) @(posedge hclk);
      resets(0, 32'h1 << i, 1'b1);
      // the first of the two waits above already spent one held cycle
      n = 1;
      while (phy_rst[i] === 1'b1 && n < 99)
      begin
        n++;
        @(posedge hclk);
      end
      chk("phy_len", (i == 2) ? 32'(VPHYC) : 32'(PHYC), 32'(n));
      poll(OFF_RESET_CONTROL_REG, 32'h2 << i, 0);
      repeat (2) @(posedge hclk);
      chk("irq_on", 1, 32'(irq));
      bus(1'b1, OFF_IRQ_MASK, 0);
      repeat (2) @(posedge hclk);
      chk("irq_mask", 0, 32'(irq));
      bus(1'b1, OFF_IRQ_STS, 32'h2 << i);
      bus(1'b1, OFF_IRQ_MASK, 32'h2 << i);
      repeat (2) @(posedge hclk);
      chk("irq_clr", 0, 32'(irq));
    end
    $display("test phy_resets done");
    scr = $urandom;
    old = straps;
    bus(1'b1, OFF_SCRATCH, scr);
    straps <= ~straps;
    nbytes <= 4'($urandom);
    bus(1'b1, OFF_RESET_CONTROL_REG, 32'h1);
    repeat (2) @(posedge hclk);
    resets(32'hFF, 0, 1'b0);
    bus(1'b0, OFF_RESET_CONTROL_REG, 0);
    chk("dig_busy", 1, d & 32'h1);
    poll(OFF_BYTE_TEST, 32'hFFFFFFFF, PAT);
    poll(OFF_HARDWARE_CONFIG_REG, 32'h1, 32'h1);
    bus(1'b0, OFF_RESET_CONTROL_REG, 0);
    chk("dig_clr", 0, d & 32'h1);
    chk("strap_keep", 32'(old), 32'(strap_val));
    bus(1'b0, OFF_SCRATCH, 0);
    chk("scratch", scr, d);
    $display("test digital_reset done");
    straps <= 8'($urandom);
    nbytes <= 4'($urandom);
    pin <= 1'b1;
    repeat (3) @(posedge hclk);
    resets(32'hFF, 32'h7, 1'b0);
    pin <= 1'b0;
    @(posedge hclk);
    poll(OFF_BYTE_TEST, 32'hFFFFFFFF, PAT);
    poll(OFF_HARDWARE_CONFIG_REG, 32'h1, 32'h1);
    chk("strap_pin", 32'(straps), 32'(strap_val));
    bus(1'b0, OFF_SCRATCH, 0);
    chk("scratch_pin", 0, d);
    bus(1'b0, 8'h40, 0);
    chk("unmapped", 0, d);
    chk("hresp", 0, 32'(hresp));
    $display("test pin_reset done");
    summarize();
  end
endmodule
`default_nettype wire
